// [src/flyback_pkg.sv]
// How it works
// - ignore current trip 220 ns after turn-on
// - after blanking, current trip ends the pulse
// - normal start needs period expiry plus valley
// - valley armed after sense drops below 100 mV
// - low loop level: fixed maximum period, no valley
// - valley needs ring peak above 0.6 V
// - no valley: 12.7 us wait, then 100 mV crossing
// - dimmer flag high from power-up
// - time 1 V to 5 V rise each half-cycle
// - four slow rises clear the dimmer flag
// - four fast rises set flag at 1 V fall
// - overvoltage: gate low, dimmer high, stop
// - overvoltage: discharge clamp until undervoltage, restart
// - overcurrent: gate low, setpoint to minimum
// - after overcurrent resume at 5 V crossing
// - overtemperature: stop, discharge clamp until undervoltage
// - hold until cool, resume at minimum light
// - standby after clamp ready until 5 V line
// - undervoltage lockout holds switching off
package flyback_pkg;
	localparam int CLK_MHZ = 20;
	localparam int BLANK_NS = 220;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK_W = 3;
	localparam int VWAIT_NS = 12700;
	localparam int VWAIT_CYC = (VWAIT_NS * CLK_MHZ) / 1000;
	localparam int VWAIT_W = 8;
	localparam int DIM_NS = 135000;
	localparam int DIM_CYC = (DIM_NS * CLK_MHZ) / 1000;
	localparam int DIM_W = 12;
	localparam int RUN_LEN = 4;
	localparam int RUN_W = 3;
	localparam int PER_W = 16;
	localparam int NPIN = 11;
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_PERIOD_MAX = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [15:0] PERIOD_RST = 16'h0090;
	localparam logic [15:0] PERIOD_MAX_RST = 16'h03E8;
	localparam int STAT_GATE = 0;
	localparam int STAT_DIM = 1;
	localparam int STAT_DISCH = 2;
	localparam int STAT_SETPT = 3;
	localparam int STAT_STATE = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {S_UNDERVOLTAGE_LOCKOUT, S_STANDBY, S_ON, S_OFF, S_OCP_HOLD, S_DISCH, S_HOT_HOLD} seq_state_e;
endpackage

// [src/flyback_regs.sv]
`timescale 1ns/1ps
module flyback_regs import flyback_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [PER_W-1:0] period, // nominal period in cycles
	output logic [PER_W-1:0] period_max, // clamp period in cycles
	input wire logic [31:0] status // live state word
);
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// merge low two byte lanes under their strobes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	wire do_write = aw_held && w_held && !bvalid;
	wire wr_period = do_write && aw_addr == ADDR_PERIOD;
	wire wr_pmax = do_write && aw_addr == ADDR_PERIOD_MAX;
	wire wr_hit = aw_addr == ADDR_PERIOD || aw_addr == ADDR_PERIOD_MAX || aw_addr == ADDR_STATUS;
	wire rd_hit = araddr == ADDR_PERIOD || araddr == ADDR_PERIOD_MAX || araddr == ADDR_STATUS;
	wire [31:0] rd_word = araddr == ADDR_PERIOD ? {16'h0000, period} :
		araddr == ADDR_PERIOD_MAX ? {16'h0000, period_max} :
		araddr == ADDR_STATUS ? status : 32'h00000000;

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period <= PERIOD_RST;
			period_max <= PERIOD_MAX_RST;
		end else begin
			if (wr_period)
				period <= merge16(period, w_data, w_strb);
			if (wr_pmax)
				period_max <= merge16(period_max, w_data, w_strb);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// [src/flyback_switch_sequencer.sv]
`timescale 1ns/1ps
module flyback_switch_sequencer import flyback_pkg::*; (
	input wire logic SYS_CLK, // 20 MHz clock
	input wire logic RST, // async reset, high
	input wire logic PWM_TRIP, // shunt at pwm threshold
	input wire logic OCP_TRIP, // shunt above 700 mV
	input wire logic VALLEY_ZC, // valley sense below 100 mV
	input wire logic VALLEY_PEAK, // valley sense above 0.6 V
	input wire logic COMP_LOW, // loop level below 1.63 V
	input wire logic LINE_1V, // line sense above 1 V
	input wire logic LINE_5V, // line sense above 5 V
	input wire logic SUPPLY_OV, // 23 V supply clamp active
	input wire logic SUPPLY_UV, // supply below 8 V
	input wire logic CLAMP_READY, // clamp node in regulation
	input wire logic OVERTEMP, // die too hot
	output logic GATE_DRIVE, // switch drive
	output logic DIMMER_FOUND, // dimmer detected
	output logic CLAMP_DISCHARGE, // clamp node pull-down
	output logic SETPOINT_RESET, // setpoint filter to minimum
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // byte enables
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY // read data ready
);
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] prev;
	seq_state_e st;
	seq_state_e next_state;
	logic [PER_W-1:0] period;
	logic [PER_W-1:0] period_max;
	logic [PER_W-1:0] period_cnt;
	logic [BLANK_W-1:0] blank_cnt;
	logic [VWAIT_W-1:0] vw_cnt;
	logic zc_seen;
	logic peak_seen;
	logic timing;
	logic [DIM_W-1:0] dly_cnt;
	logic [RUN_W-1:0] slow_run;
	logic [RUN_W-1:0] fast_run;
	logic next_dimmer;
	logic [31:0] status_word;

	//////////////////////////////////////////////////////////////////////////////
	// comparator flags, two flops each before use
	wire [NPIN-1:0] pins_raw = {PWM_TRIP, OCP_TRIP, VALLEY_ZC, VALLEY_PEAK, COMP_LOW,
		LINE_1V, LINE_5V, SUPPLY_OV, SUPPLY_UV, CLAMP_READY, OVERTEMP};

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sync1 <= '0;
			sync2 <= '0;
			prev <= '0;
		end else begin
			sync1 <= pins_raw;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	wire trip_s = sync2[10];
	wire ocp_s = sync2[9];
	wire zc_s = sync2[8];
	wire peak_s = sync2[7];
	wire comp_low_s = sync2[6];
	wire line1_s = sync2[5];
	wire line5_s = sync2[4];
	wire ov_s = sync2[3];
	wire uv_s = sync2[2];
	wire ready_s = sync2[1];
	wire hot_s = sync2[0];
	wire zc_rise = zc_s && !prev[8];
	wire line1_rise = line1_s && !prev[5];
	wire line1_fall = !line1_s && prev[5];
	wire line5_rise = line5_s && !prev[4];

	//////////////////////////////////////////////////////////////////////////////
	// cycle timing
	wire kill = ov_s || hot_s;
	wire fault = kill || ocp_s;
	wire blank_done = blank_cnt == BLANK_W'(BLANK_CYC);
	wire [PER_W-1:0] period_lim = comp_low_s ? period_max : period;
	wire period_done = period_cnt >= period_lim;
	wire vw_done = vw_cnt == VWAIT_W'(VWAIT_CYC);
	wire valley_evt = zc_seen && peak_seen && zc_rise;
	wire late_zc = vw_done && zc_rise;
	wire start = period_done && (comp_low_s || valley_evt || late_zc);
	wire in_cycle = st == S_ON || st == S_OFF;

	always_comb begin
		next_state = st;
		unique case (st)
			S_UNDERVOLTAGE_LOCKOUT: begin
				if (!uv_s && ready_s)
					next_state = S_STANDBY;
			end
			S_STANDBY: begin
				if (kill)
					next_state = S_DISCH;
				else if (uv_s)
					next_state = S_UNDERVOLTAGE_LOCKOUT;
				else if (line5_s)
					next_state = S_ON;
			end
			S_ON, S_OFF: begin
				if (kill)
					next_state = S_DISCH;
				else if (ocp_s)
					next_state = S_OCP_HOLD;
				else if (uv_s)
					next_state = S_UNDERVOLTAGE_LOCKOUT;
				else if (st == S_ON && blank_done && trip_s)
					next_state = S_OFF;
				else if (st == S_OFF && start)
					next_state = S_ON;
			end
			S_OCP_HOLD: begin
				if (kill)
					next_state = S_DISCH;
				else if (uv_s)
					next_state = S_UNDERVOLTAGE_LOCKOUT;
				else if (line5_rise)
					next_state = S_ON;
			end
			S_DISCH: begin
				if (uv_s)
					next_state = hot_s ? S_HOT_HOLD : S_UNDERVOLTAGE_LOCKOUT;
			end
			S_HOT_HOLD: begin
				if (!hot_s)
					next_state = S_UNDERVOLTAGE_LOCKOUT;
			end
			default: next_state = S_UNDERVOLTAGE_LOCKOUT;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			st <= S_UNDERVOLTAGE_LOCKOUT;
		else
			st <= next_state;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			period_cnt <= '0;
			blank_cnt <= '0;
		end else begin
			if (next_state == S_ON && st != S_ON)
				period_cnt <= '0;
			else if (in_cycle && !period_done)
				period_cnt <= period_cnt + 1'b1;
			if (st == S_ON && !blank_done)
				blank_cnt <= blank_cnt + 1'b1;
			else if (st != S_ON)
				blank_cnt <= '0;
		end
	end

	// valley detector arming, cleared at every new pulse
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			zc_seen <= 1'b0;
			peak_seen <= 1'b0;
			vw_cnt <= '0;
		end else if (st != S_OFF) begin
			zc_seen <= 1'b0;
			peak_seen <= 1'b0;
			vw_cnt <= '0;
		end else begin
			if (zc_s && !comp_low_s)
				zc_seen <= 1'b1;
			if (zc_seen && peak_s)
				peak_seen <= 1'b1;
			if (period_done && !comp_low_s && !vw_done)
				vw_cnt <= vw_cnt + 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// dimmer detection on line sense rise time
	wire measured = timing && line5_rise;
	wire slow = dly_cnt > DIM_W'(DIM_CYC);

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			timing <= 1'b0;
			dly_cnt <= '0;
		end else if (line1_rise) begin
			timing <= 1'b1;
			dly_cnt <= '0;
		end else if (measured || line1_fall) begin
			timing <= 1'b0;
		end else if (timing && dly_cnt != '1) begin
			dly_cnt <= dly_cnt + 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			slow_run <= '0;
			fast_run <= '0;
		end else if (measured) begin
			slow_run <= slow ? (slow_run == RUN_W'(RUN_LEN) ? slow_run : slow_run + 1'b1) : '0;
			fast_run <= !slow ? (fast_run == RUN_W'(RUN_LEN) ? fast_run : fast_run + 1'b1) : '0;
		end
	end

	always_comb begin
		next_dimmer = DIMMER_FOUND;
		if (ov_s)
			next_dimmer = 1'b1;
		else if (measured && slow && slow_run >= RUN_W'(RUN_LEN - 1))
			next_dimmer = 1'b0;
		else if (!DIMMER_FOUND && fast_run >= RUN_W'(RUN_LEN) && line1_fall)
			next_dimmer = 1'b1;
	end

	//////////////////////////////////////////////////////////////////////////////
	// registered pin outputs
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			GATE_DRIVE <= 1'b0;
			DIMMER_FOUND <= 1'b1;
			CLAMP_DISCHARGE <= 1'b0;
			SETPOINT_RESET <= 1'b0;
		end else begin
			GATE_DRIVE <= next_state == S_ON;
			DIMMER_FOUND <= next_dimmer;
			CLAMP_DISCHARGE <= next_state == S_DISCH;
			SETPOINT_RESET <= next_state == S_OCP_HOLD || next_state == S_DISCH ||
				next_state == S_HOT_HOLD;
		end
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[STAT_GATE] = GATE_DRIVE;
		status_word[STAT_DIM] = DIMMER_FOUND;
		status_word[STAT_DISCH] = CLAMP_DISCHARGE;
		status_word[STAT_SETPT] = SETPOINT_RESET;
		status_word[STAT_STATE +: 3] = st;
	end

	flyback_regs regs (
		.clk(SYS_CLK),
		.rst(RST),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.period(period),
		.period_max(period_max),
		.status(status_word)
	);

	//////////////////////////////////////////////////////////////////////////////
	blank_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(GATE_DRIVE) |-> (GATE_DRIVE || fault || uv_s)[*5])
		else $error("gate ended inside blanking");

	trip_end_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st == S_ON && blank_done && trip_s) |=> !GATE_DRIVE)
		else $error("current trip did not end pulse");

	period_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		($rose(GATE_DRIVE) && $past(st) == S_OFF) |-> $past(period_done))
		else $error("pulse before period expiry");

	clamp_wait_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st == S_OFF && comp_low_s && period_cnt < period_max) |=> !$rose(GATE_DRIVE))
		else $error("pulse before clamp period");

	late_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st == S_OFF && !fault && !uv_s && period_done && late_zc) |=> GATE_DRIVE)
		else $error("no pulse after valley wait");

	ov_kill_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		ov_s |=> !GATE_DRIVE && DIMMER_FOUND)
		else $error("overvoltage not handled");

	ocp_kill_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(ocp_s && in_cycle) |=> !GATE_DRIVE && SETPOINT_RESET)
		else $error("overcurrent not handled");

	disch_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st == S_DISCH && !uv_s) |=> CLAMP_DISCHARGE && !GATE_DRIVE)
		else $error("discharge dropped early");

	dim_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(measured && slow && slow_run == RUN_W'(RUN_LEN - 1) && !ov_s) |=> !DIMMER_FOUND)
		else $error("dimmer flag not cleared");

	undervoltage_lockout_off_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(uv_s && st != S_DISCH && st != S_HOT_HOLD) |=> !GATE_DRIVE)
		else $error("switching under lockout");
endmodule

// [dv/flyback_far_side.sv]
`timescale 1ns/1ps
module flyback_far_side (
	input wire logic clk, // system clock
	input wire logic gate, // switch drive
	input wire logic ring_ok, // ring peak above 0.6 V
	input wire logic [7:0] trip_dly, // on cycles before current trip
	output logic pwm_trip, // shunt at pwm threshold
	output logic valley_zc, // aux sense below 100 mV
	output logic valley_peak // aux sense above 0.6 V
);
	logic [7:0] on_cnt = 8'h00;
	logic [5:0] ph = 6'h00;
	always_ff @(posedge clk) begin
		on_cnt <= gate ? on_cnt + 8'h01 : 8'h00;
		ph <= (gate || ph == 6'h27) ? 6'h00 : ph + 6'h01;
	end
	// the negative clamp while on reads as below 100 mV
	assign pwm_trip = gate && (on_cnt >= trip_dly);
	assign valley_zc = gate || (ph >= 6'h14 && ph < 6'h1E);
	assign valley_peak = !gate && ring_ok && (ph < 6'h0A);
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top import flyback_pkg::*; ;
	logic clk = 0, rst = 1, overcurrent_fault = 0, cl = 0, l1 = 0, l5 = 0, ov = 0, uv = 1, crdy = 0, ot = 0, ring = 1;
	logic ptrip, zc, pk, gate, dim, dis, spr, awr, wrd, bv, arr, rv;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] tdly = 8'h0A, awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd_, rdat;
	logic [3:0] ws = 4'hF;
	logic [1:0] br, rr, resp;
	int error_cnt = 0, n_compared = 0, seed = 86283, rises = 0, w, p, per, r0, i, j;
	flyback_switch_sequencer i_dut (.SYS_CLK(clk), .RST(rst), .PWM_TRIP(ptrip), .OCP_TRIP(overcurrent_fault),
		.VALLEY_ZC(zc), .VALLEY_PEAK(pk), .COMP_LOW(cl), .LINE_1V(l1), .LINE_5V(l5), .SUPPLY_OV(ov),
		.SUPPLY_UV(uv), .CLAMP_READY(crdy), .OVERTEMP(ot), .GATE_DRIVE(gate), .DIMMER_FOUND(dim),
		.CLAMP_DISCHARGE(dis), .SETPOINT_RESET(spr), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
	flyback_far_side i_far (.clk(clk), .gate(gate), .ring_ok(ring), .trip_dly(tdly),
		.pwm_trip(ptrip), .valley_zc(zc), .valley_peak(pk));
	initial forever #25 clk = ~clk;
	always @(posedge gate) rises++;
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("%0d compared, %0d wrong", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic rng(input string nm, input int lo, input int hi, input int v);
		n_compared++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask
	task automatic tmo(input int n, input int b);
		n_compared++;
		if (n >= b) begin
			error_cnt++;
			$display("wrong value wait expected answer seen none");
			wrap_up;
		end
	endtask
	function automatic int wait_lo(input int pr);
		return pr + VWAIT_CYC;
	endfunction
	task automatic pause(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tw;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		n = 0;
		@(negedge clk);
		while (bv !== 1'b1 && n < 50) begin
			ta = awv && awr;
			tw = wv && wrd;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			@(negedge clk);
			n++;
		end
		tmo(n, 50);
		r = br;
		@(posedge clk) bre <= 0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta;
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rre <= 1;
		n = 0;
		@(negedge clk);
		while (rv !== 1'b1 && n < 50) begin
			ta = arv && arr;
			@(posedge clk);
			if (ta) arv <= 0;
			@(negedge clk);
			n++;
		end
		tmo(n, 50);
		d = rd_;
		r = rr;
		@(posedge clk) rre <= 0;
	endtask
	task automatic meas(output int wh, output int pr);
		int n;
		n = 0;
		while (gate !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		tmo(n, 3000);
		wh = 0;
		while (gate === 1'b1 && wh < 3000) begin
			@(negedge clk);
			wh++;
		end
		pr = wh;
		while (gate !== 1'b1 && pr < 3000) begin
			@(negedge clk);
			pr++;
		end
		tmo(pr, 3000);
	endtask
	task automatic rise_in(input int b);
		int n, s;
		n = 0;
		s = rises;
		while (rises == s && n < b) begin
			@(negedge clk);
			n++;
		end
		tmo(n, b);
	endtask
	task automatic half(input int rc);
		@(posedge clk) l1 <= 1;
		l5 <= 0;
		repeat (rc) @(posedge clk);
		l5 <= 1;
		repeat (200) @(posedge clk);
		l5 <= 0;
		repeat (20) @(posedge clk);
		l1 <= 0;
		repeat (100) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		pause(1);
		chk("dimmer_found", 1, dim);
		chk("gate", 0, gate);
		axr(ADDR_PERIOD, rdat, resp);
		chk("period", PERIOD_RST, rdat);
		axr(ADDR_PERIOD_MAX, rdat, resp);
		chk("period_max", PERIOD_MAX_RST, rdat);
		axr(8'h0C, rdat, resp);
		chk("rresp", RESP_SLVERR, resp);
		per = 48 + ($random(seed) & 63);
		// only the low lane is enabled, so the upper data bytes must not land
		@(posedge clk) ws <= 4'h1;
		axw(ADDR_PERIOD, 32'hFFFF5500 | per, resp);
		@(posedge clk) ws <= 4'hF;
		chk("bresp", RESP_OKAY, resp);
		axr(ADDR_PERIOD, rdat, resp);
		chk("period", per, rdat);
		axw(8'h10, 32'hFFFF, resp);
		chk("bresp", RESP_SLVERR, resp);
		axw(ADDR_STATUS, 32'h0, resp);
		chk("bresp", RESP_OKAY, resp);
		$display("registers done");
		@(posedge clk) crdy <= 1;
		uv <= 0;
		pause(100);
		chk("starts", 0, rises);
		@(posedge clk) l1 <= 1;
		l5 <= 1;
		rise_in(20);
		@(posedge clk) tdly <= 8'h00;
		meas(w, p);
		meas(w, p);
		rng("blanked width", 6, 9, w);
		@(posedge clk) tdly <= 8'h0A;
		meas(w, p);
		meas(w, p);
		rng("trip width", 11, 15, w);
		rng("valley period", per, per + 90, p);
		@(posedge clk) ring <= 0;
		meas(w, p);
		meas(w, p);
		rng("wait period", wait_lo(per), wait_lo(per) + 60, p);
		@(posedge clk) ring <= 1;
		cl <= 1;
		meas(w, p);
		meas(w, p);
		rng("clamp period", PERIOD_MAX_RST, PERIOD_MAX_RST + 6, p);
		@(posedge clk) cl <= 0;
		$display("switching done");
		@(posedge clk) overcurrent_fault <= 1;
		pause(6);
		chk("gate", 0, gate);
		chk("setpoint_reset", 1, spr);
		axr(ADDR_STATUS, rdat, resp);
		chk("status", (32'h1 << STAT_DIM) | (32'h1 << STAT_SETPT) | (32'(S_OCP_HOLD) << STAT_STATE), rdat);
		// line low here too, so the resume edge below is not taken as a rise-time sample
		@(posedge clk) overcurrent_fault <= 0;
		l5 <= 0;
		l1 <= 0;
		r0 = rises;
		pause(300);
		chk("starts", r0, rises);
		@(posedge clk) l5 <= 1;
		rise_in(300);
		chk("setpoint_reset", 0, spr);
		$display("overcurrent done");
		// slow, fast, slow: the flag falls, rises at the 1 V fall, falls again
		for (j = 0; j < 3; j++) begin
			for (i = 0; i < 4; i++) begin
				half(j == 1 ? 2400 : 2900);
				chk("dimmer_found", j == 1 ? i == 3 : i < 3, dim);
			end
		end
		$display("dimmer done");
		@(posedge clk) ov <= 1;
		pause(6);
		chk("gate", 0, gate);
		chk("dimmer_found", 1, dim);
		chk("discharge", 1, dis);
		@(posedge clk) ov <= 0;
		r0 = rises;
		pause(300);
		chk("discharge", 1, dis);
		chk("starts", r0, rises);
		@(posedge clk) uv <= 1;
		pause(100);
		chk("discharge", 0, dis);
		chk("starts", r0, rises);
		@(posedge clk) uv <= 0;
		l5 <= 1;
		rise_in(300);
		$display("overvoltage done");
		@(posedge clk) ot <= 1;
		pause(6);
		chk("gate", 0, gate);
		chk("discharge", 1, dis);
		@(posedge clk) uv <= 1;
		pause(6);
		chk("discharge", 0, dis);
		@(posedge clk) uv <= 0;
		r0 = rises;
		pause(300);
		chk("starts", r0, rises);
		chk("setpoint_reset", 1, spr);
		@(posedge clk) ot <= 0;
		rise_in(300);
		$display("overtemperature done");
		wrap_up;
	end
endmodule
